// ===== src/msd_map.svh
// Address map, field positions and timing counts of the memory space decoder
`ifndef MSD_MAP_SVH
`define MSD_MAP_SVH
// On-chip SRAM holding lower RAM, upper RAM and the special function space
`define MSD_RAM_BYTES      384
`define MSD_IDX_W          9
// Base index of the special function space inside the SRAM
`define MSD_SFR_BASE       9'h100
// First byte of the bit-addressable block after the register banks
`define MSD_BIT_BASE       9'h020
`define MSD_BIT_TOP        9'h02F
`define MSD_BANK_TOP       9'h01F
// Upper limit of indirect and stack addressing
`define MSD_IND_TOP        9'h0FF
// Implemented special function registers, one bit per offset 0x00..0x7F (86 set)
`define MSD_SFR_IMPL       128'h073F_1F3F_1F3F_1F3F_1F3F_1F3F_1F3F_1F3F
// External bus timing in core clocks
`define MSD_ALE_CYCLES     1
`define MSD_STROBE_CYCLES  2
`endif

// ===== src/msd_pkg.sv
// Types shared by the memory space decoder
package msd_pkg;
    // Address space of one core request
    typedef enum logic [2:0] {
        MSD_DIRECT   = 3'h0,
        MSD_INDIRECT = 3'h1,
        MSD_REG      = 3'h2,
        MSD_BIT      = 3'h3,
        MSD_STACK    = 3'h4,
        MSD_CODE     = 3'h5,
        MSD_XDATA    = 3'h6
    } msd_space_e;
    // External bus cycle states, Gray coded along the cycle
    typedef enum logic [1:0] {
        MSD_BUS_IDLE   = 2'h0,
        MSD_BUS_LATCH  = 2'h1,
        MSD_BUS_STROBE = 2'h3,
        MSD_BUS_FINISH = 2'h2
    } msd_bus_e;
endpackage

// ===== src/msd_decode.sv
// Internal memory decode, on-chip SRAM and external multiplexed bus sequencer
`timescale 1ns/1ps
`include "msd_map.svh"

// Operation
// - Internal memories live in 384-byte SRAM
// - Program and data external spaces separate
// - Program fetches use program store strobe
// - Data reads and writes use strobes
// - Internal accesses keep external strobes idle
// - Lower 128 bytes direct and indirect
// - Register operands use one selected bank
// - Bytes 0x20-0x2F hold 128 bits
// - Upper 128 bytes indirect only
// - Stack spans all 256 bytes indirectly
// - Special space has 86 registers
// - Row-aligned special registers are bit-addressable
// - Security bit blocks test port access
// - Companion reached over multiplexed external bus
// - Address latch strobe precedes data phase
module msd_decode #(
    parameter int STROBE_CYCLES = `MSD_STROBE_CYCLES
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic                 req_valid,
    output logic                      req_ready,
    input  wire msd_pkg::msd_space_e  req_space,
    input  wire logic [15:0]          req_addr,
    input  wire logic                 req_write,
    input  wire logic [7:0]           req_wdata,
    input  wire logic [1:0]           bank_sel,
    output logic                      resp_valid,
    output logic [7:0]                resp_rdata,
    output logic                      resp_reserved,
    output logic [7:0]                addr_high_byte,
    output logic [7:0]                muxed_addr_data_low_o,
    input  wire logic [7:0]           muxed_addr_data_low_i,
    output logic                      muxed_addr_data_low_oe,
    output logic                      rd_n,
    output logic                      wr_n,
    output logic                      program_store_strobe_n,
    output logic                      ale,
    output logic                      companion_reset_n,
    input  wire logic                 test_req,
    input  wire logic                 security_bit,
    output logic                      test_grant,
    output logic                      test_refused
);
    localparam logic [127:0] SFR_IMPL = `MSD_SFR_IMPL;
    localparam logic [3:0]   STB_LAST = 4'(STROBE_CYCLES - 1);

    logic [7:0]         ram_ff [`MSD_RAM_BYTES];
    msd_pkg::msd_bus_e  state_ff;
    logic [3:0]         cnt_ff;
    logic [15:0]        lat_addr_ff;
    logic [7:0]         lat_data_ff;
    logic               lat_write_ff;
    logic               lat_code_ff;
    logic               resp_valid_ff;
    logic [7:0]         resp_rdata_ff;
    logic               resp_reserved_ff;
    logic               comp_rst_ff;
    logic               test_s1_ff;
    logic               test_s2_ff;
    logic               test_s3_ff;
    logic               test_lvl_ff;
    logic               test_grant_ff;
    logic               test_refused_ff;
    logic               ext_req;
    logic               int_hit;
    logic [`MSD_IDX_W-1:0] idx;
    logic [2:0]         bit_pos;
    logic               is_bit;
    logic               reserved;
    logic [7:0]         rd_byte;
    logic [7:0]         wr_byte;
    logic               in_strobe;

    // Request split between internal SRAM and the external bus
    // separate spaces
    assign ext_req   = req_valid && (req_space == msd_pkg::MSD_CODE ||
                                     req_space == msd_pkg::MSD_XDATA);
    assign req_ready = (state_ff == msd_pkg::MSD_BUS_IDLE);
    assign int_hit   = req_valid && req_ready && !ext_req;

    // Internal address decode into the on-chip SRAM index
    always_comb begin
        idx      = '0;
        bit_pos  = 3'h0;
        is_bit   = 1'b0;
        reserved = 1'b0;
        case (req_space)
            msd_pkg::MSD_DIRECT: begin
                if (req_addr[7]) begin
                    idx      = `MSD_SFR_BASE | {2'h0, req_addr[6:0]};
                    reserved = !SFR_IMPL[req_addr[6:0]];
                end else begin
                    idx = {1'b0, req_addr[7:0]};
                end
            end
            msd_pkg::MSD_INDIRECT: idx = {1'b0, req_addr[7:0]};
            msd_pkg::MSD_STACK: idx = {1'b0, req_addr[7:0]};
            msd_pkg::MSD_REG: idx = {4'h0, bank_sel, req_addr[2:0]};
            msd_pkg::MSD_BIT: begin
                is_bit  = 1'b1;
                bit_pos = req_addr[2:0];
                if (req_addr[7]) begin
                    idx      = `MSD_SFR_BASE | {2'h0, req_addr[6:3], 3'h0};
                    reserved = !SFR_IMPL[{req_addr[6:3], 3'h0}];
                end else begin
                    idx = `MSD_BIT_BASE | {5'h0, req_addr[6:3]};
                end
            end
            default: idx = '0;
        endcase
    end

    // Read data and merged write data for byte and bit accesses
    always_comb begin
        rd_byte = reserved ? 8'h00 : ram_ff[idx];
        wr_byte = req_wdata;
        if (is_bit) begin
            wr_byte          = ram_ff[idx];
            wr_byte[bit_pos] = req_wdata[0];
            rd_byte          = {7'h00, rd_byte[bit_pos]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (int_hit && req_write && !reserved) begin
            ram_ff[idx] <= wr_byte;
        end
    end

    // External bus cycle sequencer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= msd_pkg::MSD_BUS_IDLE;
            cnt_ff   <= 4'h0;
        end else begin
            case (state_ff)
                msd_pkg::MSD_BUS_IDLE: begin
                    if (ext_req) begin
                        state_ff <= msd_pkg::MSD_BUS_LATCH;
                    end
                end
                msd_pkg::MSD_BUS_LATCH: begin
                    state_ff <= msd_pkg::MSD_BUS_STROBE;
                    cnt_ff   <= STB_LAST;
                end
                msd_pkg::MSD_BUS_STROBE: begin
                    if (cnt_ff == 4'h0) begin
                        state_ff <= msd_pkg::MSD_BUS_FINISH;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                msd_pkg::MSD_BUS_FINISH: state_ff <= msd_pkg::MSD_BUS_IDLE;
                default: state_ff <= msd_pkg::MSD_BUS_IDLE;
            endcase
        end
    end

    // Address, data and direction held for the whole bus cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_addr_ff  <= 16'h0000;
            lat_data_ff  <= 8'h00;
            lat_write_ff <= 1'b0;
            lat_code_ff  <= 1'b0;
        end else if (ext_req && req_ready) begin
            lat_addr_ff  <= req_addr;
            lat_data_ff  <= req_wdata;
            lat_code_ff  <= (req_space == msd_pkg::MSD_CODE);
            lat_write_ff <= req_write && (req_space == msd_pkg::MSD_XDATA);
        end
    end

    // companion bus pins from held state
    assign in_strobe              = (state_ff == msd_pkg::MSD_BUS_STROBE);
    assign addr_high_byte         = lat_addr_ff[15:8];
    assign ale                    = (state_ff == msd_pkg::MSD_BUS_LATCH);
    assign program_store_strobe_n = !(in_strobe && lat_code_ff);
    assign rd_n                   = !(in_strobe && !lat_code_ff && !lat_write_ff);
    assign wr_n                   = !(in_strobe && !lat_code_ff && lat_write_ff);
    assign muxed_addr_data_low_o  = ale ? lat_addr_ff[7:0] : lat_data_ff;
    assign muxed_addr_data_low_oe = ale || (in_strobe && lat_write_ff);
    assign companion_reset_n      = comp_rst_ff;

    // Answer for internal accesses and every external read or write
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid_ff    <= 1'b0;
            resp_rdata_ff    <= 8'h00;
            resp_reserved_ff <= 1'b0;
        end else begin
            resp_valid_ff    <= int_hit || (in_strobe && cnt_ff == 4'h0);
            resp_reserved_ff <= int_hit && reserved;
            if (int_hit) begin
                resp_rdata_ff <= rd_byte;
            end else if (in_strobe && cnt_ff == 4'h0) begin
                resp_rdata_ff <= lat_write_ff ? 8'h00 : muxed_addr_data_low_i;
            end
        end
    end
    assign resp_valid    = resp_valid_ff;
    assign resp_rdata    = resp_rdata_ff;
    assign resp_reserved = resp_reserved_ff;

    // Companion die held in reset with the core
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            comp_rst_ff <= 1'b0;
        end else begin
            comp_rst_ff <= 1'b1;
        end
    end

    // Test port request synchroniser, change taken when stages agree
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            test_s1_ff  <= 1'b0;
            test_s2_ff  <= 1'b0;
            test_s3_ff  <= 1'b0;
            test_lvl_ff <= 1'b0;
        end else begin
            test_s1_ff <= test_req;
            test_s2_ff <= test_s1_ff;
            test_s3_ff <= test_s2_ff;
            if (test_s2_ff == test_s3_ff) begin
                test_lvl_ff <= test_s3_ff;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            test_grant_ff   <= 1'b0;
            test_refused_ff <= 1'b0;
        end else begin
            test_grant_ff   <= test_lvl_ff && !security_bit;
            test_refused_ff <= test_lvl_ff && security_bit;
        end
    end
    assign test_grant   = test_grant_ff;
    assign test_refused = test_refused_ff;

    // Bus cycle phases
    sequence seq_latch_phase;
        ale && muxed_addr_data_low_oe && rd_n && wr_n && program_store_strobe_n;
    endsequence
    sequence seq_strobe_phase;
        (!ale && (!rd_n || !wr_n || !program_store_strobe_n))[*2];
    endsequence

    AST_SRAM_BOUND: assert property (@(posedge core_clk) disable iff (!rst_n)
        int_hit |-> idx < 9'(`MSD_RAM_BYTES))
        else $error("internal index outside SRAM");
    AST_BUS_CYCLE: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ext_req && req_ready) |=> seq_latch_phase ##1 seq_strobe_phase
        ##1 (resp_valid && !req_ready && rd_n && wr_n && program_store_strobe_n)
        ##1 req_ready)
        else $error("external cycle phases wrong");
    AST_FETCH_STROBE: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ext_req && req_ready && req_space == msd_pkg::MSD_CODE)
        |=> ##1 (!program_store_strobe_n && rd_n && wr_n)[*2])
        else $error("fetch used data strobes");
    AST_DATA_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        $fell(rd_n) |-> $past(ale) && wr_n && program_store_strobe_n)
        else $error("read strobe without address phase");
    AST_INT_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
        int_hit |-> (rd_n && wr_n && program_store_strobe_n && !ale)
        ##1 (rd_n && wr_n && program_store_strobe_n && !ale && req_ready))
        else $error("strobe active on internal access");
    AST_BANK_MAP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (int_hit && req_space == msd_pkg::MSD_REG)
        |-> idx <= `MSD_BANK_TOP && idx[4:3] == bank_sel)
        else $error("register outside selected bank");
    AST_BIT_BLOCK: assert property (@(posedge core_clk) disable iff (!rst_n)
        (int_hit && req_space == msd_pkg::MSD_BIT && !req_addr[7])
        |-> idx >= `MSD_BIT_BASE && idx <= `MSD_BIT_TOP)
        else $error("bit outside bit block");
    AST_DIRECT_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
        (int_hit && req_space == msd_pkg::MSD_DIRECT && req_addr[7]) |-> idx[8])
        else $error("direct high reached upper RAM");
    AST_STACK_SPAN: assert property (@(posedge core_clk) disable iff (!rst_n)
        (int_hit && req_space == msd_pkg::MSD_STACK)
        |-> idx <= `MSD_IND_TOP && idx[7:0] == req_addr[7:0])
        else $error("stack index wrong");
    AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        (int_hit && reserved) |=> resp_valid && resp_reserved && resp_rdata == 8'h00)
        else $error("reserved slot returned data");
    AST_TEST_LOCK: assert property (@(posedge core_clk) disable iff (!rst_n)
        security_bit |=> !test_grant)
        else $error("test port granted while secured");
endmodule // msd_decode

// ===== verif/msd_companion.sv
// Behavioural companion die model on the multiplexed bus
`timescale 1ns/1ps
module msd_companion (
    input  wire logic        core_clk,
    input  wire logic [7:0]  addr_high_byte,
    input  wire logic [7:0]  muxed_addr_data_low_o,
    output logic      [7:0]  muxed_addr_data_low_i,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        program_store_strobe_n,
    input  wire logic        ale,
    output logic      [15:0] lat_addr
);
    logic [7:0] xmem [int];
    logic [7:0] last_q = 8'h00;
    always @(posedge core_clk) begin
        if (ale) begin
            lat_addr <= {addr_high_byte, muxed_addr_data_low_o};
        end
    end
    always @(posedge core_clk) begin
        if (!wr_n) begin
            xmem[lat_addr] = muxed_addr_data_low_o;
        end
        last_q <= muxed_addr_data_low_i;
    end
    always_comb begin
        if (!program_store_strobe_n) begin
            muxed_addr_data_low_i = lat_addr[7:0] ^ lat_addr[15:8] ^ 8'h5A;
        end else if (!rd_n) begin
            muxed_addr_data_low_i = xmem.exists(lat_addr) ? xmem[lat_addr]
                                  : lat_addr[7:0] + lat_addr[15:8] + 8'h33;
        end else begin
            muxed_addr_data_low_i = ~last_q; // Released bus toggles each cycle
        end
    end
endmodule // msd_companion

// ===== verif/msd_decode_tb.sv
// Self-checking bench for the memory space decoder
`timescale 1ns/1ps
`include "msd_map.svh"
module msd_decode_tb;
    logic                core_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                req_valid = 1'b0;
    msd_pkg::msd_space_e req_space = msd_pkg::MSD_DIRECT;
    logic [15:0]         req_addr = 16'h0000;
    logic                req_write = 1'b0;
    logic [7:0]          req_wdata = 8'h00;
    logic [1:0]          bank_sel = 2'h0;
    logic                test_req = 1'b0;
    logic                security_bit = 1'b0;
    logic                req_ready, resp_valid, resp_reserved, rd_n, wr_n, ps_n, ale;
    logic                oe, comp_rst_n, grant, refused;
    logic [7:0]          rdata, addr_hi, mx_o, mx_i;
    logic [15:0]         lat_addr;
    logic [7:0]          ram [256];
    logic [7:0]          special_function_space [128];
    logic [7:0]          xd [int];
    int                  n_errors = 0;
    int                  compares = 0;
    int                  seed = 32'h2e4180a9;
    int                  c_ale = 0, c_rd = 0, c_wr = 0, c_ps = 0, c_oe = 0;
    // Implemented special slots, one bit per offset
    localparam logic [127:0] SFR_MASK = `MSD_SFR_IMPL;

    always #10 core_clk = ~core_clk;

    msd_decode u_msd_decode (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_space(req_space), .req_addr(req_addr),
        .req_write(req_write), .req_wdata(req_wdata), .bank_sel(bank_sel),
        .resp_valid(resp_valid), .resp_rdata(rdata), .resp_reserved(resp_reserved),
        .addr_high_byte(addr_hi), .muxed_addr_data_low_o(mx_o),
        .muxed_addr_data_low_i(mx_i), .muxed_addr_data_low_oe(oe), .rd_n(rd_n),
        .wr_n(wr_n), .program_store_strobe_n(ps_n), .ale(ale),
        .companion_reset_n(comp_rst_n), .test_req(test_req),
        .security_bit(security_bit), .test_grant(grant), .test_refused(refused));

    msd_companion u_msd_companion (.core_clk(core_clk), .addr_high_byte(addr_hi),
        .muxed_addr_data_low_o(mx_o), .muxed_addr_data_low_i(mx_i), .rd_n(rd_n),
        .wr_n(wr_n), .program_store_strobe_n(ps_n), .ale(ale), .lat_addr(lat_addr));

    // Running counts of latch and strobe cycles
    always @(posedge core_clk) begin
        c_ale <= c_ale + int'(ale);
        c_rd <= c_rd + int'(!rd_n);
        c_wr <= c_wr + int'(!wr_n);
        c_ps <= c_ps + int'(!ps_n);
        c_oe <= c_oe + int'(oe);
    end

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        if (n_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One request, reference model update and port checks
    task automatic do_req(input int sp, input logic [15:0] a, input logic w,
                          input logic [7:0] d);
        int s0, s1, s2, s3, s4, lat, idx, bi;
        logic [1:0] b;
        logic [7:0] er;
        logic ers, ext;
        b = 2'($random(seed));
        ers = 1'b0;
        er = 8'h00;
        ext = (sp >= 5);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_space <= msd_pkg::msd_space_e'(sp);
        req_addr <= a;
        req_write <= w;
        req_wdata <= d;
        bank_sel <= b;
        lat = 0;
        do begin
            @(posedge core_clk);
            lat++;
        end while (req_ready !== 1'b1 && lat < 10);
        req_valid <= 1'b0;
        s0 = c_ale;
        s1 = c_rd;
        s2 = c_wr;
        s3 = c_ps;
        s4 = c_oe;
        lat = 0;
        do begin
            @(posedge core_clk);
            lat++;
        end while (resp_valid !== 1'b1 && lat < 10);
        idx = (sp == 2) ? int'(b) * 8 + int'(a[2:0]) : int'(a[7:0]);
        if (sp == 3) begin
            idx = a[7] ? 128 + int'(a[6:3]) * 8 : 32 + int'(a[6:3]);
        end
        if ((sp == 0 || sp == 3) && idx >= 128) begin
            ers = !SFR_MASK[idx - 128];
            if (!ers && w) special_function_space[idx - 128] = (sp == 3) ? (special_function_space[idx - 128] & ~(8'h01 << a[2:0]))
                | (8'(d[0]) << a[2:0]) : d;
            er = ers ? 8'h00 : special_function_space[idx - 128];
        end else if (sp < 5) begin
            if (w) ram[idx] = (sp == 3) ? (ram[idx] & ~(8'h01 << a[2:0]))
                | (8'(d[0]) << a[2:0]) : d;
            er = ram[idx];
        end else if (sp == 5) begin
            er = a[7:0] ^ a[15:8] ^ 8'h5A;
        end else if (w) begin
            xd[a] = d;
        end else begin
            er = xd.exists(a) ? xd[a] : a[7:0] + a[15:8] + 8'h33;
        end
        if (sp == 3) er = 8'((er >> a[2:0]) & 8'h01);
        check("latency", 16'(lat), ext ? 16'h0004 : 16'h0001);
        check("ale", 16'(c_ale - s0), 16'(ext));
        check("rd_n", 16'(c_rd - s1), (sp == 6 && !w) ? 16'h0002 : 16'h0000);
        check("wr_n", 16'(c_wr - s2), (sp == 6 && w) ? 16'h0002 : 16'h0000);
        check("pstore", 16'(c_ps - s3), (sp == 5) ? 16'h0002 : 16'h0000);
        check("oe", 16'(c_oe - s4), 16'(ext) + ((sp == 6 && w) ? 16'h0002 : 16'h0000));
        if (ext) check("ext_addr", lat_addr, a);
        if (!w || ext) check("rdata", 16'(rdata), 16'(er));
        check("reserved", 16'(resp_reserved), 16'(ers));
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        check("comp_rst_low", 16'(comp_rst_n), 16'h0000);
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        check("comp_rst_high", 16'(comp_rst_n), 16'h0001);
        // Fill lower and upper RAM, then the whole special space
        for (int i = 0; i < 256; i++) do_req(1, 16'(i), 1'b1, 8'($random(seed)));
        for (int i = 0; i < 128; i++) do_req(0, 16'(128 + i), 1'b1, 8'($random(seed)));
        // Same external address in both spaces
        do_req(6, 16'h0010, 1'b1, 8'hC3);
        do_req(5, 16'h0010, 1'b0, 8'h00);
        do_req(6, 16'h0010, 1'b0, 8'h00);
        do_req(4, 16'h00FF, 1'b1, 8'h5C);
        do_req(4, 16'h00FF, 1'b0, 8'h00);
        for (int i = 0; i < 600; i++) begin
            do_req($unsigned($random(seed)) % 7, 16'($random(seed)),
                   1'($random(seed)), 8'($random(seed)));
        end
        // Test port with and without the security bit
        test_req <= 1'b1;
        repeat (8) @(posedge core_clk);
        check("grant", {grant, refused}, 16'h0002);
        security_bit <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("refused", {grant, refused}, 16'h0001);
        test_req <= 1'b0;
        repeat (8) @(posedge core_clk);
        check("idle", {grant, refused}, 16'h0000);
        final_report();
    end
endmodule // msd_decode_tb
